// ==== core/spicsb_top.sv ====
// Serial port with configuration/status register, shifter and APB slave.
// Assumes APB master on core_clk_i; link pins are asynchronous and synchronised here.
//
// Overview of operation
// - Slave-selected flag reads 1 while de-glitched select pin is low.
// - Slave-selected flag reads 0 while de-glitched select pin is high.
// - Raw select level bit returns pin level without de-glitch filtering.
// - Shifter-empty sets once shifting done and nothing pending for shifter.
// - Shifter-empty clears on transmit byte load or serial clock edge in slave mode; in master mode it always reads 1.
// - Clock polarity one idles serial clock high, zero idles low.
`timescale 1ns/1ps
`default_nettype none
module spicsb_top
	import spicsb_pkg::*;
#(
	parameter logic [7:0] DIV_HALF = SPICSB_DEF_DIV_HALF,
	parameter logic [3:0] GLITCH_CYCLES = SPICSB_DEF_GLITCH
)(
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic irq_o,
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe_n_o,
	input wire logic mosi_i,
	output logic mosi_o,
	output logic mosi_oe_n_o,
	input wire logic miso_i,
	output logic miso_o,
	output logic miso_oe_n_o,
	input wire logic slave_select_pin_i
);

	typedef struct packed {
		logic master_select;
		logic clock_phase_select;
		logic clock_polarity_select;
		logic serial_port_enable;
		logic [7:0] tx_buf;
		logic tx_full;
		logic [7:0] rx_buf;
		logic rx_full;
		logic [7:0] shreg;
		logic out_bit;
		logic loaded;
		logic [3:0] bit_cnt;
		logic shifter_empty;
		logic m_active;
		logic m_sck;
		logic [4:0] half_cnt;
		logic [7:0] div_cnt;
		logic sck_d;
		logic [1:0] int_status;
		logic [1:0] int_mask;
		logic [31:0] rdata;
	} spicsb_state_t;

	spicsb_state_t s;
	spicsb_state_t next_s;

	logic [3:0] pins_sync;
	logic sck_s;
	logic mosi_s;
	logic miso_s;
	logic raw_select_pin_level;
	logic select_filt;

	logic setup;
	logic acc_wr;
	logic acc_rd;
	logic mapped;
	logic sel_active;
	logic rise;
	logic fall;
	logic smp;
	logic shf;
	logic din;
	logic done;
	logic load;
	logic busy;
	logic slave_selected_flag;
	logic shifter_empty_flag;
	logic receive_buffer_empty_flag;
	logic [7:0] cfg_rd;
	logic [31:0] rd_mux;
	logic [1:0] events;
	logic [1:0] w1c;

	spicsb_sync #(
		.WIDTH(4),
		.RESET_VAL(4'h8)
	) u_sync (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.async_i({slave_select_pin_i, miso_i, mosi_i, sck_i}),
		.sync_o(pins_sync)
	);

	assign sck_s = pins_sync[0];
	assign mosi_s = pins_sync[1];
	assign miso_s = pins_sync[2];
	assign raw_select_pin_level = pins_sync[3];

	spicsb_deglitch #(
		.STABLE_CYCLES(GLITCH_CYCLES),
		.RESET_VAL(1'b1)
	) u_deglitch (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.level_i(raw_select_pin_level),
		.level_o(select_filt)
	);

	assign setup = psel_i & ~penable_i;
	assign acc_wr = psel_i & penable_i & pwrite_i & mapped;
	assign acc_rd = psel_i & penable_i & ~pwrite_i & mapped;
	assign mapped = (paddr_i == SPICSB_OFF_CFG) || (paddr_i == SPICSB_OFF_CTRL) ||
		(paddr_i == SPICSB_OFF_DATA) || (paddr_i == SPICSB_OFF_INT_STATUS) ||
		(paddr_i == SPICSB_OFF_INT_MASK);

	// Status view
	assign busy = s.m_active | (s.bit_cnt != 4'h0);
	assign slave_selected_flag = ~select_filt;
	assign shifter_empty_flag = s.master_select | s.shifter_empty;
	assign receive_buffer_empty_flag = s.master_select | ~s.rx_full;

	always_comb
	begin
		cfg_rd = 8'h00;
		cfg_rd[SPICSB_BIT_BUSY] = busy;
		cfg_rd[SPICSB_BIT_MASTER] = s.master_select;
		cfg_rd[SPICSB_BIT_CPHA] = s.clock_phase_select;
		cfg_rd[SPICSB_BIT_CPOL] = s.clock_polarity_select;
		cfg_rd[SPICSB_BIT_SLVSELD] = slave_selected_flag;
		cfg_rd[SPICSB_BIT_RAWSEL] = raw_select_pin_level;
		cfg_rd[SPICSB_BIT_SHEMPTY] = shifter_empty_flag;
		cfg_rd[SPICSB_BIT_RXEMPTY] = receive_buffer_empty_flag;
	end

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (paddr_i)
			SPICSB_OFF_CFG: rd_mux[7:0] = cfg_rd;
			SPICSB_OFF_CTRL: rd_mux[SPICSB_BIT_ENABLE] = s.serial_port_enable;
			SPICSB_OFF_DATA: rd_mux[7:0] = s.rx_buf;
			SPICSB_OFF_INT_STATUS: rd_mux[1:0] = s.int_status;
			SPICSB_OFF_INT_MASK: rd_mux[1:0] = s.int_mask;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_comb
	begin
		next_s = s;
		rise = 1'b0;
		fall = 1'b0;
		done = 1'b0;
		load = 1'b0;
		w1c = 2'h0;
		sel_active = ~s.master_select & s.serial_port_enable & ~select_filt;

		// Register bus
		if (setup)
			next_s.rdata = rd_mux;
		if (acc_wr)
		begin
			unique case (paddr_i)
				SPICSB_OFF_CFG:
				begin
					next_s.master_select = pwdata_i[SPICSB_BIT_MASTER];
					next_s.clock_phase_select = pwdata_i[SPICSB_BIT_CPHA];
					next_s.clock_polarity_select = pwdata_i[SPICSB_BIT_CPOL];
				end
				SPICSB_OFF_CTRL: next_s.serial_port_enable = pwdata_i[SPICSB_BIT_ENABLE];
				SPICSB_OFF_DATA:
				begin
					if (!s.tx_full)
					begin
						next_s.tx_buf = pwdata_i[7:0];
						next_s.tx_full = 1'b1;
					end
				end
				SPICSB_OFF_INT_STATUS: w1c = pwdata_i[1:0];
				SPICSB_OFF_INT_MASK: next_s.int_mask = pwdata_i[1:0];
				default: next_s.int_mask = s.int_mask;
			endcase
		end
		if (acc_rd && paddr_i == SPICSB_OFF_DATA)
			next_s.rx_full = 1'b0;

		// Serial clock edges: own divider as master, pin edges as slave
		if (s.master_select)
		begin
			if (s.m_active)
			begin
				if (s.div_cnt >= DIV_HALF - 8'h01)
				begin
					next_s.div_cnt = 8'h00;
					next_s.m_sck = ~s.m_sck;
					rise = ~s.m_sck;
					fall = s.m_sck;
					next_s.half_cnt = s.half_cnt + 5'h01;
					if (s.half_cnt == SPICSB_HALF_LAST)
						next_s.m_active = 1'b0;
				end
				else
					next_s.div_cnt = s.div_cnt + 8'h01;
			end
		end
		else if (sel_active)
		begin
			rise = sck_s & ~s.sck_d;
			fall = ~sck_s & s.sck_d;
		end
		next_s.sck_d = sck_s;

		smp = (s.clock_polarity_select == s.clock_phase_select) ? rise : fall;
		shf = (s.clock_polarity_select == s.clock_phase_select) ? fall : rise;
		din = s.master_select ? miso_s : mosi_s;

		if (smp)
		begin
			next_s.shreg = {s.shreg[6:0], din};
			if (s.bit_cnt == SPICSB_BIT_LAST)
			begin
				next_s.bit_cnt = 4'h0;
				done = 1'b1;
			end
			else
				next_s.bit_cnt = s.bit_cnt + 4'h1;
		end
		if (shf)
			next_s.out_bit = s.shreg[7];
		if (rise || fall)
			next_s.loaded = 1'b0;
		if (done)
		begin
			next_s.rx_buf = {s.shreg[6:0], din};
			next_s.rx_full = 1'b1;
		end

		// Deselect or disable aborts a partial byte
		if (!s.serial_port_enable || (!s.master_select && select_filt))
			next_s.bit_cnt = 4'h0;
		if (!s.serial_port_enable)
			next_s.m_active = 1'b0;

		load = s.serial_port_enable & s.tx_full & ~s.loaded & (s.bit_cnt == 4'h0) &
			~s.m_active & ~(rise | fall);
		if (load)
		begin
			next_s.shreg = s.tx_buf;
			next_s.out_bit = s.tx_buf[7];
			next_s.tx_full = 1'b0;
			next_s.loaded = 1'b1;
			if (s.master_select)
			begin
				next_s.m_active = 1'b1;
				next_s.half_cnt = 5'h00;
				next_s.div_cnt = 8'h00;
			end
		end

		if (!s.m_active || !s.master_select)
			next_s.m_sck = s.clock_polarity_select;

		if (load || rise || fall)
			next_s.shifter_empty = 1'b0;
		else if (s.bit_cnt == 4'h0 && !s.loaded && !s.tx_full)
			next_s.shifter_empty = 1'b1;

		// Sticky events, set wins over clear
		events = 2'h0;
		events[SPICSB_INT_DONE] = done;
		events[SPICSB_INT_OVERRUN] = done & s.rx_full & ~(acc_rd && paddr_i == SPICSB_OFF_DATA);
		next_s.int_status = (s.int_status & ~w1c) | events;
	end

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			s <= '0;
			s.master_select <= SPICSB_RST_MASTER;
			s.clock_phase_select <= SPICSB_RST_CPHA;
			s.clock_polarity_select <= SPICSB_RST_CPOL;
			s.serial_port_enable <= SPICSB_RST_ENABLE;
			s.int_mask <= SPICSB_RST_INT_MASK;
			s.shifter_empty <= 1'b1;
		end
		else
			s <= next_s;
	end

	assign prdata_o = s.rdata;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~mapped;
	assign irq_o = |(s.int_status & s.int_mask);

	assign sck_o = s.m_sck;
	assign sck_oe_n_o = ~(s.serial_port_enable & s.master_select);
	assign mosi_o = s.out_bit;
	assign mosi_oe_n_o = ~(s.serial_port_enable & s.master_select);
	assign miso_o = s.out_bit;
	assign miso_oe_n_o = ~(s.serial_port_enable & ~s.master_select & ~select_filt);

endmodule : spicsb_top
`default_nettype wire

// ==== core/spicsb_pkg.sv ====
// Package for the serial port configuration and status block.
// Assumes an APB register bus with 32-bit data and one word per register.
package spicsb_pkg;

	// Register byte offsets
	localparam logic [7:0] SPICSB_OFF_CFG = 8'h00;
	localparam logic [7:0] SPICSB_OFF_CTRL = 8'h04;
	localparam logic [7:0] SPICSB_OFF_DATA = 8'h08;
	localparam logic [7:0] SPICSB_OFF_INT_STATUS = 8'h0c;
	localparam logic [7:0] SPICSB_OFF_INT_MASK = 8'h10;

	// Field positions of serial_port_config_status
	localparam int SPICSB_BIT_BUSY = 7;
	localparam int SPICSB_BIT_MASTER = 6;
	localparam int SPICSB_BIT_CPHA = 5;
	localparam int SPICSB_BIT_CPOL = 4;
	localparam int SPICSB_BIT_SLVSELD = 3;
	localparam int SPICSB_BIT_RAWSEL = 2;
	localparam int SPICSB_BIT_SHEMPTY = 1;
	localparam int SPICSB_BIT_RXEMPTY = 0;

	// Control register and interrupt bits
	localparam int SPICSB_BIT_ENABLE = 0;
	localparam int SPICSB_INT_DONE = 0;
	localparam int SPICSB_INT_OVERRUN = 1;

	// Values after reset
	localparam logic SPICSB_RST_MASTER = 1'b0;
	localparam logic SPICSB_RST_CPHA = 1'b0;
	localparam logic SPICSB_RST_CPOL = 1'b0;
	localparam logic SPICSB_RST_ENABLE = 1'b0;
	localparam logic [1:0] SPICSB_RST_INT_MASK = 2'h0;

	// Counts
	localparam logic [3:0] SPICSB_BIT_LAST = 4'h7;
	localparam logic [4:0] SPICSB_HALF_LAST = 5'h0f;
	localparam logic [7:0] SPICSB_DEF_DIV_HALF = 8'h04;
	localparam logic [3:0] SPICSB_DEF_GLITCH = 4'h3;

endpackage : spicsb_pkg

// ==== core/spicsb_sync.sv ====
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to core_clk_i.
`timescale 1ns/1ps
`default_nettype none
module spicsb_sync
	import spicsb_pkg::*;
#(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
)(
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} spicsb_sync_t;

	spicsb_sync_t s;
	spicsb_sync_t next_s;

	always_comb
	begin
		next_s.s1 = async_i;
		next_s.s2 = s.s1;
	end

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			s <= {RESET_VAL, RESET_VAL};
		else
			s <= next_s;
	end

	assign sync_o = s.s2;

endmodule : spicsb_sync
`default_nettype wire

// ==== core/spicsb_deglitch.sv ====
// De-glitch filter: output follows input only after it stays stable.
// Assumes a synchronised input on core_clk_i.
`timescale 1ns/1ps
`default_nettype none
module spicsb_deglitch
	import spicsb_pkg::*;
#(
	parameter logic [3:0] STABLE_CYCLES = SPICSB_DEF_GLITCH,
	parameter logic RESET_VAL = 1'b1
)(
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic level_i,
	output logic level_o
);

	typedef struct packed {
		logic level;
		logic [3:0] cnt;
	} spicsb_dg_t;

	spicsb_dg_t s;
	spicsb_dg_t next_s;

	always_comb
	begin
		next_s = s;
		if (level_i == s.level)
			next_s.cnt = 4'h0;
		else if (s.cnt >= STABLE_CYCLES - 4'h1)
		begin
			next_s.level = level_i;
			next_s.cnt = 4'h0;
		end
		else
			next_s.cnt = s.cnt + 4'h1;
	end

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			s <= {RESET_VAL, 4'h0};
		else
			s <= next_s;
	end

	assign level_o = s.level;

endmodule : spicsb_deglitch
`default_nettype wire

// ==== test/spicsb_chk_sva.sv ====
// Checker for the serial port config/status block.
// Assumes binding onto spicsb_top, APB on core_clk_i.
`timescale 1ns/1ps
`default_nettype none
module spicsb_chk
	import spicsb_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pslverr_o,
	input wire logic sck_o,
	input wire logic slave_select_pin_i
);
	logic master_q;
	wire logic cfg_rd = psel_i && !penable_i && !pwrite_i && paddr_i == SPICSB_OFF_CFG;
	wire logic cfg_wr = psel_i && penable_i && pwrite_i && paddr_i == SPICSB_OFF_CFG;
	wire logic dat_wr = psel_i && penable_i && pwrite_i && paddr_i == SPICSB_OFF_DATA;
	always_ff @(posedge core_clk_i or negedge rstn_i)
		if (!rstn_i)
			master_q <= 1'b0;
		else if (cfg_wr)
			master_q <= pwdata_i[SPICSB_BIT_MASTER];
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	sequence s_pin_lo;
		!slave_select_pin_i [*8];
	endsequence
	sequence s_pin_hi;
		slave_select_pin_i [*8];
	endsequence
	sequence s_load_read;
		dat_wr && !master_q ##2 cfg_rd;
	endsequence
	a_err_unmapped: assert property (psel_i && penable_i && paddr_i > SPICSB_OFF_INT_MASK |-> pslverr_o)
		else $error("no error on unmapped access");
	a_sel_set: assert property (s_pin_lo ##0 cfg_rd |=> prdata_o[SPICSB_BIT_SLVSELD])
		else $error("selected flag not set");
	a_sel_clear: assert property (s_pin_hi ##0 cfg_rd |=> !prdata_o[SPICSB_BIT_SLVSELD])
		else $error("selected flag not clear");
	a_raw_low: assert property (s_pin_lo ##0 cfg_rd |=> !prdata_o[SPICSB_BIT_RAWSEL])
		else $error("raw level not low");
	a_raw_high: assert property (s_pin_hi ##0 cfg_rd |=> prdata_o[SPICSB_BIT_RAWSEL])
		else $error("raw level not high");
	a_load_clears: assert property (s_load_read |=> !prdata_o[SPICSB_BIT_SHEMPTY])
		else $error("shifter empty after load");
	a_sck_idle: assert property (cfg_wr |-> ##2 sck_o == $past(pwdata_i[SPICSB_BIT_CPOL], 2))
		else $error("clock idle level wrong");
	a_master_empty: assert property (cfg_rd && master_q |=> prdata_o[1:0] == 2'b11)
		else $error("empty flags not set in master");
endmodule : spicsb_chk
bind spicsb_top spicsb_chk i_chk (.core_clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
	.pwdata_i, .prdata_o, .pslverr_o, .sck_o, .slave_select_pin_i);
`default_nettype wire

// ==== test/spicsb_link_model.sv ====
// Far-side link master driving clock, data and select.
// Assumes mode 0 and an 80 ns link clock.
`timescale 1ns/1ps
`default_nettype none
module spicsb_link_model
(
	output logic sck_o,
	output logic mosi_o,
	output logic sel_n_o,
	input wire logic miso_i
);
	initial
	begin
		sck_o = 1'b0;
		mosi_o = 1'b0;
		sel_n_o = 1'b1;
	end
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		#3;
		sel_n_o = 1'b0;
		#80;
		for (int i = 7; i >= 0; i--)
		begin
			mosi_o = tx[i];
			#40;
			sck_o = 1'b1;
			rx[i] = miso_i;
			#40;
			sck_o = 1'b0;
		end
		#40;
		sel_n_o = 1'b1;
		// Released data line wanders
		mosi_o = ~mosi_o;
	endtask : xfer
endmodule : spicsb_link_model
`default_nettype wire

// ==== test/tb.sv ====
// Testbench for the serial port config/status block.
// Assumes the link model as far-side master.
`timescale 1ns/1ps
`default_nettype none
module tb
	import spicsb_pkg::*;
;
	localparam logic [7:0] CFG = SPICSB_OFF_CFG;
	localparam logic [7:0] DAT = SPICSB_OFF_DATA;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, r;
	logic pready, pslverr, irq, err_s, sck_d, sck_oe_n, mosi_d, mosi_oe_n, miso_d, miso_oe_n;
	logic m_sck, m_mosi, m_sel_n;
	logic [7:0] rx;
	int errors = 0;
	int compares = 0;
	wire logic sck_w = sck_oe_n ? m_sck : sck_d;
	wire logic mosi_w = mosi_oe_n ? m_mosi : mosi_d;
	// Pull-up on the return line
	wire logic miso_w = miso_oe_n ? 1'b1 : miso_d;
	spicsb_top i_dut (.core_clk_i(clk), .rstn_i(rst_n), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .irq_o(irq), .sck_i(sck_w), .sck_o(sck_d), .sck_oe_n_o(sck_oe_n),
		.mosi_i(mosi_w), .mosi_o(mosi_d), .mosi_oe_n_o(mosi_oe_n), .miso_i(miso_w), .miso_o(miso_d),
		.miso_oe_n_o(miso_oe_n), .slave_select_pin_i(m_sel_n));
	spicsb_link_model i_link (.sck_o(m_sck), .mosi_o(m_mosi), .sel_n_o(m_sel_n), .miso_i(miso_w));
	initial
	begin
		forever #4 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		r = prdata;
		err_s = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic t_reset();
		apb(1'b0, CFG, 32'h0);
		chk(r, 32'h07);
		apb(1'b0, 8'h14, 32'h0);
		chk(r, 32'h0);
		chk({31'h0, err_s}, 32'h1);
	endtask : t_reset
	task automatic t_slave();
		apb(1'b1, SPICSB_OFF_CTRL, 32'h1);
		apb(1'b1, DAT, 32'ha5);
		apb(1'b0, CFG, 32'h0);
		chk(r & 32'h2, 32'h0);
		fork
			i_link.xfer(8'h3c, rx);
			begin
				repeat (40) @(posedge clk);
				apb(1'b0, CFG, 32'h0);
				chk(r & 32'hc, 32'h8);
				chk({29'h0, sck_oe_n, mosi_oe_n, miso_oe_n}, 32'h6);
			end
		join
		chk({24'h0, rx}, 32'ha5);
		repeat (10) @(posedge clk);
		apb(1'b0, SPICSB_OFF_INT_STATUS, 32'h0);
		chk(r, 32'h1);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, SPICSB_OFF_INT_MASK, 32'h1);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, SPICSB_OFF_INT_STATUS, 32'h1);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, DAT, 32'h0);
		chk(r, 32'h3c);
		apb(1'b0, CFG, 32'h0);
		chk(r, 32'h07);
		fork
			i_link.xfer(8'h5a, rx);
			begin
				repeat (40) @(posedge clk);
				apb(1'b0, CFG, 32'h0);
				chk(r & 32'h2, 32'h0);
			end
		join
		repeat (10) @(posedge clk);
		apb(1'b0, DAT, 32'h0);
		chk(r, 32'h5a);
	endtask : t_slave
	task automatic m_send(input logic [31:0] cfg, input logic [7:0] tx);
		logic [7:0] mtx;
		mtx = 8'h00;
		// Port off before phase or polarity change
		apb(1'b1, SPICSB_OFF_CTRL, 32'h0);
		apb(1'b1, CFG, cfg);
		apb(1'b1, SPICSB_OFF_CTRL, 32'h1);
		chk({31'h0, sck_d}, {31'h0, cfg[SPICSB_BIT_CPOL]});
		fork
			// Data line taken on the sample edge of the selected mode
			repeat (8)
			begin
				if (cfg[SPICSB_BIT_CPOL] == cfg[SPICSB_BIT_CPHA])
					@(posedge sck_d);
				else
					@(negedge sck_d);
				mtx = {mtx[6:0], mosi_d};
			end
			begin
				apb(1'b1, DAT, {24'h0, tx});
				chk({29'h0, sck_oe_n, mosi_oe_n, miso_oe_n}, 32'h1);
				apb(1'b0, CFG, 32'h0);
				chk(r & 32'h83, 32'h83);
				for (int i = 0; i < 60 && r[7] !== 1'b0; i++)
					apb(1'b0, CFG, 32'h0);
			end
		join
		chk(r, cfg | 32'h07);
		chk({31'h0, sck_d}, {31'h0, cfg[SPICSB_BIT_CPOL]});
		chk({24'h0, mtx}, {24'h0, tx});
	endtask : m_send
	task automatic t_master();
		m_send(32'h50, 8'h81);
		// Unread byte left in place so the second byte overruns
		m_send(32'h60, 8'h36);
		apb(1'b0, SPICSB_OFF_INT_STATUS, 32'h0);
		chk(r, 32'h3);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, SPICSB_OFF_INT_STATUS, 32'h3);
		apb(1'b0, SPICSB_OFF_INT_STATUS, 32'h0);
		chk(r, 32'h0);
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, DAT, 32'h0);
		chk(r, 32'hff);
	endtask : t_master
	task automatic wrap_up();
		if (errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_slave();
		t_master();
		wrap_up();
	end
	initial
	begin
		#100000;
		errors++;
		wrap_up();
	end
endmodule : tb
`default_nettype wire
